// >>> long_range_timer_pkg.sv
// Purpose: Shared constants and types for the long-range timer/counter.
// Assumes: One 40 MHz clock; time-base period set by a named time constant.
// Notes:   Cycle counts are derived from times in ns by rounding rules.
package long_range_timer_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  // Time-base period T and the width of each low-going time-base pulse.
  localparam int TB_PERIOD_NS  = 1000;
  localparam int TB_PULSE_NS   = 100;
  // Period is a least time (round up); pulse width is a least time too.
  localparam int TB_PERIOD_CYC = (TB_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TB_PULSE_CYC  = (TB_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------------
  localparam int CNT_W   = 8;
  localparam int TBCNT_W = 6;
  localparam int SYNC_W  = 3;
  localparam logic [TBCNT_W-1:0] TB_LAST  = TBCNT_W'(TB_PERIOD_CYC - 1);
  localparam logic [TBCNT_W-1:0] TB_LOW_AT = TBCNT_W'(TB_PERIOD_CYC - TB_PULSE_CYC);
  localparam logic [CNT_W-1:0]   CNT_RST  = 8'h00;
  localparam logic [TBCNT_W-1:0] TBCNT_RST = 6'h00;
  localparam logic [SYNC_W-1:0]  SYNC_RST = 3'h0;
  localparam logic [SYNC_W-1:0]  TBSYNC_RST = 3'h7;

  // Control and counting state carried as one unit.
  typedef struct packed {
    logic               running;
    logic [CNT_W-1:0]   count;
    logic [TBCNT_W-1:0] tbCount;
  } timer_state_t;

  // Filtered levels of the three pin inputs.
  typedef struct packed {
    logic trig;
    logic rst;
    logic node;
  } pin_levels_t;

endpackage

// >>> long_range_timer_counter.sv
// Purpose: Long-delay timer/counter: control flip-flop, gated time-base, 8-bit counter.
// Assumes: Trigger, reset and time-base node arrive from pins; open-collector drives.
// Notes:   Node level is read back on tbNodeIn, so external clocks and clamps act too.
//          Trigger and stop act as levels, so a held trigger restarts once idle.
//
// Notes on behaviour
// [R1] Time-base, eight-stage counter, control flip-flop.
// [R2] Reset state releases all counter outputs high.
// [R3] Trigger drives timing output low 128 periods.
// [R4] Unfed-back output toggles every 128 periods.
// [R5] Output fed to reset ends monostable cycle.
// [R6] Far side pulses trigger to start, reset to stop.
// [R7] Triggers ignored while timing runs.
// [R8] Power-up without controls enters reset state.
// [R9] Trigger overrides reset when both active.
// [R10] Time-base high in reset, pulses when triggered.
// [R11] Counter advances on node falling edges.
// [R12] Clamping node low freezes the count.
// [R13] External clock on node replaces time-base.
// [R14] First stage output square wave, two periods.
// [R15] Cascade: unit output clocks next counter.
// [R16] Sequential: second unit triggered at completion.
// [R17] Astable runs from trigger until reset.
// [R18] Free-running: held trigger self-starts after power-up.
// [R19] Timing output is counter MSB, cleared on trigger.
`timescale 1ns/1ps

module long_range_timer_counter (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       trigPin,
  input  wire logic       resetPin,
  input  wire logic       tbEnable,
  input  wire logic       tbNodeIn,
  output logic            tbNodeOut,
  output logic            tbNodeOe,
  output logic [7:0]      counterOut,
  output logic [7:0]      counterOe
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [long_range_timer_pkg::SYNC_W-1:0] trigSync_q;
  logic [long_range_timer_pkg::SYNC_W-1:0] trigSync_d;
  logic [long_range_timer_pkg::SYNC_W-1:0] rstSync_q;
  logic [long_range_timer_pkg::SYNC_W-1:0] rstSync_d;
  logic [long_range_timer_pkg::SYNC_W-1:0] nodeSync_q;
  logic [long_range_timer_pkg::SYNC_W-1:0] nodeSync_d;
  long_range_timer_pkg::pin_levels_t       lvl_q;
  long_range_timer_pkg::pin_levels_t       lvl_d;
  logic                                    tbFall;

  // Shift pins in; a level is accepted once the second and third stages agree.
  always_comb begin
    trigSync_d = {trigSync_q[1:0], trigPin};
    rstSync_d  = {rstSync_q[1:0], resetPin};
    nodeSync_d = {nodeSync_q[1:0], tbNodeIn};
    lvl_d      = lvl_q;
    if (trigSync_q[1] == trigSync_q[2]) begin
      lvl_d.trig = trigSync_q[2];
    end
    if (rstSync_q[1] == rstSync_q[2]) begin
      lvl_d.rst = rstSync_q[2];
    end
    if (nodeSync_q[1] == nodeSync_q[2]) begin
      lvl_d.node = nodeSync_q[2];
    end
  end

  // Registers of the synchronisers and filtered levels.
  // The node rests high so that leaving reset never looks like a falling edge.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      trigSync_q <= long_range_timer_pkg::SYNC_RST;
      rstSync_q  <= long_range_timer_pkg::SYNC_RST;
      nodeSync_q <= long_range_timer_pkg::TBSYNC_RST;
      lvl_q      <= '{trig: 1'b0, rst: 1'b0, node: 1'b1};
    end else begin
      trigSync_q <= trigSync_d;
      rstSync_q  <= rstSync_d;
      nodeSync_q <= nodeSync_d;
      lvl_q      <= lvl_d;
    end
  end

  // The filter's next level is used so that an edge counts one cycle sooner.
  // [R11] node falling edge
  assign tbFall = lvl_q.node & ~lvl_d.node;

  // ----------------------------------------------------------------------
  // Control flip-flop, time-base and counter
  // ----------------------------------------------------------------------
  long_range_timer_pkg::timer_state_t st_q;
  long_range_timer_pkg::timer_state_t st_d;
  logic                               startNow;
  logic                               tbOe_d;
  logic [7:0]                         cntOe_d;

  // [R1] Next state of the control flip-flop, time-base and ripple counter.
  always_comb begin
    st_d     = st_q;
    startNow = 1'b0;
    // [R18] held trigger self-starts
    // [R9] trigger beats reset
    if (lvl_q.trig) begin
      // [R7] trigger ignored while running
      if (!st_q.running) begin
        // [R3] start and clear counter
        startNow     = 1'b1;
        st_d.running = 1'b1;
        st_d.count   = long_range_timer_pkg::CNT_RST;
        st_d.tbCount = long_range_timer_pkg::TBCNT_RST;
      end
    end else if (lvl_q.rst) begin
      // [R5] reset ends the cycle
      st_d.running = 1'b0;
      st_d.count   = long_range_timer_pkg::CNT_RST;
      st_d.tbCount = long_range_timer_pkg::TBCNT_RST;
    end
    if (st_q.running && !startNow && !(lvl_q.rst && !lvl_q.trig)) begin
      // [R10] time-base runs only while timing
      if (tbEnable) begin
        if (st_q.tbCount == long_range_timer_pkg::TB_LAST) begin
          st_d.tbCount = long_range_timer_pkg::TBCNT_RST;
        end else begin
          st_d.tbCount = st_q.tbCount + 6'h01;
        end
      end
      // [R13] any falling edge on the node counts, internal or external
      if (tbFall) begin
        // [R4] wraps past full
        // [R14] bit zero toggles
        // [R15] cascade edges count
        st_d.count = st_q.count + 8'h01;
      end
    end
  end

  // [R2] Outputs released while idle; a stage sinks current while its bit is zero.
  always_comb begin
    tbOe_d  = st_d.running && tbEnable && (st_d.tbCount >= long_range_timer_pkg::TB_LOW_AT);
    // Next state is used so that each pin leaves its flip-flop in step with the count.
    // [R16] released MSB triggers followers
    // [R19] output level follows counter bits
    cntOe_d = st_d.running ? ~st_d.count : 8'h00;
  end

  // [R8] Reset brings the control flip-flop to its rest state.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q       <= '{running: 1'b0, count: long_range_timer_pkg::CNT_RST,
                      tbCount: long_range_timer_pkg::TBCNT_RST};
      tbNodeOe   <= 1'b0;
      tbNodeOut  <= 1'b0;
      counterOe  <= 8'h00;
      counterOut <= 8'h00;
    end else begin
      st_q       <= st_d;
      tbNodeOe   <= tbOe_d;
      tbNodeOut  <= 1'b0;
      counterOe  <= cntOe_d;
      counterOut <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  // All checks run on the one clock and pause while reset is high.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence tbLowPulse;
    (tbNodeOe || !st_q.running)[*4] ##1 !tbNodeOe;
  endsequence

  sequence startSeen;
    st_q.running && st_q.count == 8'h00 && counterOe[7];
  endsequence

  sequence countHalf;
    st_q.count == 8'h80;
  endsequence

  // Rest state, control flip-flop, counter stepping and time-base pulse.
  idle_released_a: assert property (!st_q.running |-> counterOe == 8'h00 && !tbNodeOe) // [R2]
    else $error("Outputs not released while idle.");
  trigger_start_a: assert property (!st_q.running && lvl_q.trig |=> startSeen) // [R3]
    else $error("Trigger did not start with output low.");
  trigger_wins_a: assert property (st_q.running && lvl_q.trig |=> st_q.running) // [R9]
    else $error("Running stopped while trigger active.");
  reset_stops_a: assert property (lvl_q.rst && !lvl_q.trig |=> !st_q.running) // [R17]
    else $error("Reset did not stop the timer.");
  count_step_a: assert property (st_q.running && !lvl_q.trig && !lvl_q.rst && tbFall // [R11]
                                 |=> st_q.count == $past(st_q.count) + 8'h01)
    else $error("Counter did not advance on falling edge.");
  clamp_hold_a: assert property (st_q.running && !lvl_q.rst && !tbFall // [R12]
                                 |=> $stable(st_q.count))
    else $error("Counter moved without a falling edge.");
  tb_pulse_a: assert property ($rose(tbNodeOe) |-> tbLowPulse) // [R10]
    else $error("Time-base pulse width wrong.");
  msb_output_a: assert property (st_q.running |-> counterOe == ~st_q.count) // [R19]
    else $error("Counter outputs do not follow count.");
  powerup_rest_a: assert property ($fell(reset) |-> !st_q.running && counterOe == 8'h00) // [R8]
    else $error("Not at rest after power-up.");

  // Further control, counter and time-base checks.
  trig_run_a: assert property (lvl_q.trig |=> st_q.running) // [R18]
    else $error("Trigger level did not leave the timer running.");
  retrig_ignore_a: assert property (st_q.running && lvl_q.trig && !tbFall // [R7]
                                    |=> $stable(st_q.count))
    else $error("Retrigger disturbed the count.");
  stage_toggle_a: assert property (st_q.running && !lvl_q.rst && tbFall // [R14]
                                   |=> counterOe[0] != $past(counterOe[0]))
    else $error("First stage did not toggle.");
  count_wrap_a: assert property (st_q.running && !lvl_q.rst && tbFall // [R4]
                                 && st_q.count == 8'hFF |=> counterOe[7])
    else $error("Timing output did not return low after the full count.");
  out_release_a: assert property (st_q.running && $fell(counterOe[7]) |-> countHalf) // [R16]
    else $error("Timing output released at the wrong count.");
  ext_quiet_a: assert property (!tbEnable |=> !tbNodeOe) // [R13]
    else $error("Time-base pulsed while disabled.");

endmodule

// >>> pin_source.sv
// Purpose: Far-side model of the trigger, stop and clock sources at the pins.
// Assumes: The node and the timing pin have pull-ups; node and counter drivers are open collector, trigger and stop are plain levels.
// Notes:   The feedback input ties the timing output back to the stop input.
`timescale 1ns/1ps

module pin_source (
  input  wire logic trigReq,
  input  wire logic stopReq,
  input  wire logic feedback,
  input  wire logic extClk,
  input  wire logic clampLow,
  input  wire logic tbNodeOut,
  input  wire logic tbNodeOe,
  input  wire logic timingSink,
  output logic      trigPin,
  output logic      resetPin,
  output logic      tbNodeIn
);
  assign trigPin = trigReq;
  assign resetPin = stopReq | (feedback & ~timingSink);
  assign tbNodeIn = ~(tbNodeOe & ~tbNodeOut) & extClk & ~clampLow;  // Wired-AND with pull-up.
endmodule

// >>> tb.sv
// Purpose: Self-checking bench for the long-range timer/counter.
// Assumes: Control pulses last six cycles, well past the input filter.
// Notes:   Counter pin level is the inverse of its output enable.
`timescale 1ns/1ps

module tb;
  logic       ref_clk = 1'b0;
  logic       reset = 1'b1;
  logic       trigReq = 1'b0;
  logic       stopReq = 1'b0;
  logic       feedback = 1'b0;
  logic       extClk = 1'b1;
  logic       clampLow = 1'b0;
  logic       tbEnable = 1'b1;
  logic       trigPin, resetPin, tbNodeIn, tbNodeOut, tbNodeOe;
  logic [7:0] counterOut, counterOe;
  int         numErrors = 0;
  int         nChecks = 0;
  int         n;

  // Clock at 40 MHz.
  always #12.5 ref_clk = ~ref_clk;

  long_range_timer_counter i_dut (.ref_clk(ref_clk), .reset(reset), .trigPin(trigPin),
    .resetPin(resetPin), .tbEnable(tbEnable), .tbNodeIn(tbNodeIn), .tbNodeOut(tbNodeOut),
    .tbNodeOe(tbNodeOe), .counterOut(counterOut), .counterOe(counterOe));
  pin_source i_src (.trigReq(trigReq), .stopReq(stopReq), .feedback(feedback),
    .extClk(extClk), .clampLow(clampLow), .tbNodeOut(tbNodeOut), .tbNodeOe(tbNodeOe),
    .timingSink(counterOe[7]), .trigPin(trigPin), .resetPin(resetPin), .tbNodeIn(tbNodeIn));

  // Prints the verdict and ends the run.
  task automatic summarize;
    if (numErrors == 0 && nChecks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    nChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Waits cycles, then steps just past the edge.
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #2;
  endtask

  // Pulses the control pins, then lets the filter settle.
  task automatic pulse(input logic t, input logic s);
    trigReq = t;
    stopReq = s;
    cyc(6);
    trigReq = 1'b0;
    stopReq = 1'b0;
    cyc(6);
  endtask

  // Counts cycles until the timing sink enable reaches a level.
  task automatic waitMsb(input logic lvl);
    n = 0;
    while (counterOe[7] !== lvl && n < 6000) begin
      cyc(1);
      n++;
    end
    // A wait that runs out is itself a mismatch.
    if (n >= 6000) begin
      chk(n, 16'h0000);
    end
  endtask

  // Start, first edge, ignored trigger and clamp.
  task automatic t_start;
    chk(counterOe, 8'h00);
    chk(tbNodeOe, 1'b0);
    pulse(1'b1, 1'b0);
    chk(counterOe, 8'hFF);
    chk({counterOut, tbNodeOut}, 9'h000);
    n = 0;
    while (tbNodeOe !== 1'b1 && n < 45) begin
      cyc(1);
      n++;
    end
    // Start lags the pin by five cycles and the pulse task spends twelve.
    chk(n, 16'(long_range_timer_pkg::TB_LOW_AT) + 16'h0005 - 16'h000C);
    cyc(8);
    chk(counterOe, 8'hFE);
    pulse(1'b1, 1'b0);
    chk(counterOe, 8'hFE);
    // Clamping the node is one last falling edge; the count then holds.
    clampLow = 1'b1;
    cyc(8);
    chk(counterOe, 8'hFD);
    cyc(100);
    chk(counterOe, 8'hFD);
    clampLow = 1'b0;
    pulse(1'b0, 1'b1);
    chk(counterOe, 8'h00);
  endtask

  // Astable run, priority and monostable end.
  task automatic t_cycles;
    pulse(1'b1, 1'b1);
    chk(counterOe, 8'hFF);
    waitMsb(1'b0);
    chk(n > 5090 && n < 5130, 1'b1);
    waitMsb(1'b1);
    chk(n, 16'h1400);
    pulse(1'b0, 1'b1);
    chk(counterOe, 8'h00);
    pulse(1'b1, 1'b0);
    feedback = 1'b1;
    waitMsb(1'b0);
    cyc(12);
    chk(counterOe, 8'h00);
    feedback = 1'b0;
  endtask

  // External clock replaces the time-base.
  task automatic t_ext;
    tbEnable = 1'b0;
    pulse(1'b1, 1'b0);
    repeat (5) begin
      extClk = 1'b0;
      cyc(4);
      extClk = 1'b1;
      cyc(4);
    end
    chk(counterOe, 8'hFA);
  endtask

  // Main sequence.
  initial begin
    cyc(12);
    reset = 1'b0;
    cyc(2);
    t_start();
    t_cycles();
    t_ext();
    summarize();
  end

  // Watchdog well past the expected run.
  initial begin
    #1500000;
    numErrors++;
    summarize();
  end
endmodule
